// >>> tb_upstream_burst_mode_select.sv
// tb_upstream_burst_mode_select.sv: self-checking bench of the mode selector
// assumes ubms_top, ubms_headend and ubms_properties compiled before
`timescale 1ns/10ps
`default_nettype none
`include "ubms_map.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; $display("CHECK FAILED %0t value mismatch", $time); end end
module tb_upstream_burst_mode_select;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ack = 0, rsp = 0, rst = 0, req = 0, lg = 0, bd = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, gv, ga, gd, am, cu, uc, uf, ub;
  logic [3:0] gi, rs;
  logic [1:0] av;
  logic [31:0] exq[$];
  logic t3s = 0, alw = 0, o60s = 0, ov;
  logic [7:0] oc;
  logic [2:0] hc;
  logic [3:0] hd;
  localparam logic [79:0] pfx = 80'h646f_6373_6973_312e_303a;
  int checks = 0, mismatches = 0, seed = 32'h3b59e792;
  always #12.5 pclk = ~pclk;
  ubms_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reg_ack_sent(ack), .reg_rsp_rcvd(rsp), .reg_restart(rst), .grant_valid(gv), .grant_iuc(gi),
    .grant_accept(ga), .grant_drop(gd), .req_use_long(lg), .req_size_iuc(rs), .adv_mode(am),
    .chan_usable(cu), .adv_version(av), .use_concat(uc), .use_frag(uf), .use_bpi_plus(ub),
    .opt60_start(o60s), .opt60_valid(ov), .opt60_char(oc), .opt60_busy());
  ubms_headend he_u (.pclk(pclk), .presetn(presetn), .ack_seen(ack), .rsp_seen(rsp | rst), .req(req),
    .long(lg), .bad(bd), .t3(t3s), .allow(alw), .grant_valid(gv), .grant_iuc(gi), .rsp_caps(hc),
    .ucd_desc(hd));
  // result monitor: oldest note against each read, grant answer or option 60 character
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) `CHK(prdata, exq.pop_front())
    if (ga || gd) `CHK({30'h0, gd, ga}, exq.pop_front())
    if (ov) `CHK({24'h0, oc}, exq.pop_front())
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    if (!w) exq.push_back(e);
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin mismatches++; print_verdict; end
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic grant(input logic l, input logic b, input logic [31:0] e);
    req <= 1; lg <= l; bd <= b; exq.push_back(e);
    @(posedge pclk) req <= 0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic ev(input logic [2:0] m);
    {rst, rsp, ack} <= m;
    @(posedge pclk) {rst, rsp, ack} <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, `UBMS_STAT_OFF, 0, 32'h8);
    apb(0, 12'h014, 0, 0);
    apb(1, `UBMS_UCD_OFF, 32'hf, 0);
    apb(1, `UBMS_CTRL_OFF, 32'h6, 0);
    grant(0, 0, 1);
    grant(1, 1, 2);
    apb(0, `UBMS_DROP_OFF, 0, 1);
    ev(1);
    apb(0, `UBMS_STAT_OFF, 0, 32'h7);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      grant(r[0], 0, 1);
    end
    grant(0, 1, 2);
    ev(2);
    apb(0, `UBMS_STAT_OFF, 0, 32'hc);
    grant(1, 0, 1);
    ev(1);
    ev(4);
    apb(0, `UBMS_STAT_OFF, 0, 32'hc);
    t3s <= 1;
    @(posedge pclk);
    apb(1, `UBMS_UCD_OFF, {28'h0, hd}, 0);
    apb(1, `UBMS_CTRL_OFF, 32'h7, 0);
    apb(0, `UBMS_STAT_OFF, 0, 32'h5);
    grant(1, 0, 1);
    t3s <= 0;
    $display("mode switching done");
    r = $random(seed);
    apb(1, `UBMS_CAP_OFF, r, 0);
    apb(0, `UBMS_CAP_OFF, 0, {29'h0, r[2:0]});
    `CHK({ub, uf, uc}, r[2:0])
    apb(1, `UBMS_CTRL_OFF, 32'h200, 0);
    @(posedge pclk);
    `CHK(av, 2'h1)
    apb(1, `UBMS_CTRL_OFF, 32'h20a, 0);
    @(posedge pclk);
    `CHK(av, 2'h0)
    for (int i = 0; i < 18; i++)
      exq.push_back(i < 10 ? {24'h0, pfx[79-8*i -: 8]} : {24'h0, (i < 17) ? 8'h30 : 8'h30 + r[2:0]});
    o60s <= 1;
    @(posedge pclk) o60s <= 0;
    repeat (25) @(posedge pclk);
    alw <= r[3];
    @(posedge pclk);
    apb(1, `UBMS_CAP_OFF, {29'h0, hc}, 0);
    @(posedge pclk);
    `CHK({ub, uf, uc}, r[3] ? 3'h7 : 3'h0)
    apb(1, `UBMS_UCD_OFF, 32'hc, 0);
    apb(1, `UBMS_CTRL_OFF, 32'h1, 0);
    apb(0, `UBMS_STAT_OFF, 0, 32'h8);
    apb(1, `UBMS_UCD_OFF, 32'h3, 0);
    apb(0, `UBMS_STAT_OFF, 0, 32'hc);
    $display("capability and descriptor done");
    print_verdict;
  end
endmodule
bind ubms_top ubms_properties chk_u (.*);
`default_nettype wire

// >>> ubms_headend.sv
// ubms_headend.sv: headend scheduler model issuing grants
// assumes the bench asks for grants and mirrors registration events
`timescale 1ns/10ps
`default_nettype none
`include "ubms_map.vh"
module ubms_headend (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ack_seen,
  input  wire logic       rsp_seen,
  input  wire logic       req,
  input  wire logic       long,
  input  wire logic       bad,
  input  wire logic       t3,
  input  wire logic       allow,
  output var  logic       grant_valid,
  output var  logic [3:0] grant_iuc,
  output var  logic [2:0] rsp_caps,
  output var  logic [3:0] ucd_desc
);
  logic acked_q;
  // response capabilities: deny concat and frag, force baseline privacy unless the operator allows
  // every version capability in the response stays at the oldest version
  assign rsp_caps = allow ? 3'h7 : 3'h0;
  // type 3 and code-division channels carry type 5 descriptors only; type 5 holds advanced short and long
  assign ucd_desc = t3 ? 4'hc : 4'hf;
  // grant codes follow the acknowledge; bad asks for the wrong family
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acked_q     <= 1'b0;
      grant_valid <= 1'b0;
      grant_iuc   <= 4'h0;
    end else begin
      if (ack_seen) acked_q <= 1'b1;
      else if (rsp_seen) acked_q <= 1'b0;
      grant_valid <= req;
      if (req) grant_iuc <= ((acked_q | t3) ^ bad) ? (long ? `UBMS_IUC_ADV_LONG : `UBMS_IUC_ADV_SHORT)
                                            : (long ? `UBMS_IUC_LONG : `UBMS_IUC_SHORT);
      else grant_iuc <= ~grant_iuc; // code inverted every cycle outside a grant
    end
  end
endmodule
`default_nettype wire

// >>> ubms_map.vh
// ubms_map.vh: register offsets, field positions, codes and reset values of the upstream mode selector
// assumes 32-bit apb with word-aligned registers; included by ubms_top.v
`ifndef UBMS_MAP_VH
`define UBMS_MAP_VH

// register byte offsets
`define UBMS_CTRL_OFF        12'h000
`define UBMS_CAP_OFF         12'h004
`define UBMS_STAT_OFF        12'h008
`define UBMS_UCD_OFF         12'h00c
`define UBMS_DROP_OFF        12'h010
`define UBMS_ADDR_W          12

// control register fields
`define UBMS_CTRL_CHTYPE_LO  0
`define UBMS_CTRL_CHTYPE_HI  1
`define UBMS_CTRL_ADV_CAP    2
`define UBMS_CTRL_HYBRID     3
`define UBMS_CTRL_REG_RST    4
`define UBMS_CTRL_VER_LO     8
`define UBMS_CTRL_VER_HI     9
`define UBMS_CTRL_RST        32'h0000_0000

// capability register fields (negotiated on, from the registration response)
`define UBMS_CAP_CONCAT      0
`define UBMS_CAP_FRAG        1
`define UBMS_CAP_BPIP        2
`define UBMS_CAP_W           3
`define UBMS_CAP_RST         3'h0

// channel descriptor register fields
`define UBMS_UCD_T4_SHORT    0
`define UBMS_UCD_T4_LONG     1
`define UBMS_UCD_T5_SHORT    2
`define UBMS_UCD_T5_LONG     3
`define UBMS_UCD_RST         4'h0

// status register fields
`define UBMS_STAT_ADV        0
`define UBMS_STAT_ACKED      1
`define UBMS_STAT_USABLE     2
`define UBMS_STAT_LEGACY_REQ 3

// channel types
`define UBMS_CH_TYPE1        2'h1
`define UBMS_CH_TYPE2        2'h2
`define UBMS_CH_TYPE3        2'h3

// interval usage codes
`define UBMS_IUC_SHORT       4'h5
`define UBMS_IUC_LONG        4'h6
`define UBMS_IUC_ADV_SHORT   4'h9
`define UBMS_IUC_ADV_LONG    4'ha

// protocol versions
`define UBMS_VER_W           2
`define UBMS_VER_10          2'h0
`define UBMS_VER_11          2'h1
`define UBMS_VER_20          2'h2

// option 60 prefix length in characters and capability digits
`define UBMS_PFX_LEN         4'ha
`define UBMS_HEX_LEN         4'h8
`define UBMS_MSG_LEN         5'h12
`define UBMS_CNT_W           5

`endif

// >>> ubms_properties.sv
// ubms_properties.sv: port checker of the upstream mode selector
// assumes ubms_top ports and clk_en held high
`timescale 1ns/10ps
`default_nettype none
`include "ubms_map.vh"
module ubms_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        reg_ack_sent,
  input wire logic        reg_rsp_rcvd,
  input wire logic        reg_restart,
  input wire logic        grant_valid,
  input wire logic [3:0]  grant_iuc,
  input wire logic        grant_accept,
  input wire logic        grant_drop,
  input wire logic        req_use_long,
  input wire logic [3:0]  req_size_iuc,
  input wire logic        adv_mode
);
  logic [2:0] ctl_q;
  logic       t5_q;
  wire        wr = psel && penable && pwrite;
  wire        t2 = ctl_q[1:0] == `UBMS_CH_TYPE2;
  wire        t3 = ctl_q[1:0] == `UBMS_CH_TYPE3;
  wire        leg = grant_iuc == `UBMS_IUC_SHORT || grant_iuc == `UBMS_IUC_LONG;
  wire        adv = grant_iuc == `UBMS_IUC_ADV_SHORT || grant_iuc == `UBMS_IUC_ADV_LONG;
  // shadow of channel type, capability and type 5 presence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 3'h0;
      t5_q  <= 1'b0;
    end else if (wr && paddr == `UBMS_CTRL_OFF) begin
      ctl_q <= pwdata[2:0];
    end else if (wr && paddr == `UBMS_UCD_OFF) begin
      t5_q  <= &pwdata[3:2];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_GRANT_ONE: assert property (grant_valid |=> grant_accept != grant_drop)
    else $error("grant not answered once");
  AST_DROP_ADV: assert property (grant_valid && t2 && adv_mode && leg ##1 adv_mode |-> grant_drop)
    else $error("legacy grant kept in advanced mode");
  AST_DROP_LEG: assert property (grant_valid && t2 && !adv_mode && adv ##1 !adv_mode |-> grant_drop)
    else $error("advanced grant kept in legacy mode");
  AST_KEEP_LEG: assert property (grant_valid && t2 && !adv_mode && leg ##1 !adv_mode |-> grant_accept)
    else $error("legacy grant dropped in legacy mode");
  AST_ACK_ADV: assert property (reg_ack_sent && !reg_rsp_rcvd && !reg_restart && t2 && ctl_q[2] && t5_q
    ##1 !reg_rsp_rcvd && !reg_restart
    |-> ##1 adv_mode)
    else $error("no advanced mode after acknowledge");
  AST_RSP_LEG: assert property (reg_rsp_rcvd && !t3 ##1 !reg_ack_sent |-> ##1 !adv_mode)
    else $error("response did not restore legacy mode");
  AST_RESTART_LEG: assert property (reg_restart && !t3 ##1 !reg_ack_sent |-> ##1 !adv_mode)
    else $error("restart did not restore legacy mode");
  AST_SIZE_LEG: assert property ((!adv_mode && !req_use_long)[*2] ##1 !adv_mode
    |-> req_size_iuc == `UBMS_IUC_SHORT)
    else $error("legacy sizing code wrong");
  AST_SIZE_ADV: assert property ((adv_mode && req_use_long)[*2] ##1 adv_mode
    |-> req_size_iuc == `UBMS_IUC_ADV_LONG)
    else $error("advanced sizing code wrong");
  // main scenarios reached
  cover property (reg_ack_sent ##2 adv_mode);
  cover property (grant_drop);
  cover property (reg_rsp_rcvd ##2 !adv_mode);
endmodule
`default_nettype wire

// >>> ubms_top.v
// ubms_top.v: upstream mode selector for a modem on a mixed legacy/advanced tdma channel
// assumes an apb master on pclk and a mac engine on the same clock that pulses the message events
`timescale 1ns/10ps
`default_nettype none
`include "ubms_map.vh"

// How it works
// RQ1 - before and during registration on type 1 or 2, size requests with legacy codes
// RQ2 - headend grants only legacy codes until modem registers on type 1 or 2
// RQ3 - on type 2, enter advanced mode after sending registration acknowledge
// RQ4 - a registration response after the acknowledge returns the modem to legacy mode
// RQ5 - in advanced mode, size requests from codes 9 and 10
// RQ6 - after the acknowledge the headend grants data with codes 9 and 10
// RQ7 - on type 2, drop grants whose code conflicts with current mode
// RQ8 - type 3 headend uses only type 5 descriptors and codes 9 and 10
// RQ9 - on type 2 only advanced short and long bursts are type 5 descriptors
// RQ10 - legacy modem without type 4 short or long descriptors marks channel unusable
// RQ11 - advanced modems use type 5 descriptors as well as type 4 ones
// RQ12 - code-division channel headend uses type 5 descriptors only
// RQ13 - never advertise a version above the one fully complied with
// RQ14 - hybrid modem sends option 60 prefix plus ascii hex capabilities
// RQ15 - headend by default denies concatenation and fragmentation, forces privacy
// RQ16 - non-compliant headend reports oldest version in every version capability
// RQ17 - capabilities marked off in the response are never used
// RQ18 - legacy headend turns off unknown capabilities; hybrid may leave supported on
// RQ19 - mode returns to legacy on reset and on registration restart
module ubms_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        reg_ack_sent,
  input  wire        reg_rsp_rcvd,
  input  wire        reg_restart,
  input  wire        grant_valid,
  input  wire [3:0]  grant_iuc,
  output reg         grant_accept,
  output reg         grant_drop,
  input  wire        req_use_long,
  output reg  [3:0]  req_size_iuc,
  output reg         adv_mode,
  output reg         chan_usable,
  output reg  [1:0]  adv_version,
  output reg         use_concat,
  output reg         use_frag,
  output reg         use_bpi_plus,
  input  wire        opt60_start,
  output reg         opt60_valid,
  output reg  [7:0]  opt60_char,
  output wire        opt60_busy
);

  // registers
  reg  [31:0] ctrl_q;
  reg  [2:0]  cap_q;
  reg  [3:0]  ucd_q;
  reg  [15:0] drop_cnt_q;
  reg         adv_q;
  reg         acked_q;
  reg  [4:0]  opt_cnt_q;
  reg         opt_run_q;

  wire [1:0]  ch_type   = ctrl_q[`UBMS_CTRL_CHTYPE_HI:`UBMS_CTRL_CHTYPE_LO];
  wire        adv_cap   = ctrl_q[`UBMS_CTRL_ADV_CAP];
  wire        hybrid    = ctrl_q[`UBMS_CTRL_HYBRID];
  wire [1:0]  ver_fully = ctrl_q[`UBMS_CTRL_VER_HI:`UBMS_CTRL_VER_LO];

  // apb decode: zero wait states, unmapped addresses answer with an error
  wire        acc     = psel & penable;
  wire        wr      = acc & pwrite & clk_en;
  wire        hit     = (paddr == `UBMS_CTRL_OFF) | (paddr == `UBMS_CAP_OFF) |
                        (paddr == `UBMS_STAT_OFF) | (paddr == `UBMS_UCD_OFF) |
                        (paddr == `UBMS_DROP_OFF);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  // mode decisions
  wire        mixed   = (ch_type == `UBMS_CH_TYPE1) | (ch_type == `UBMS_CH_TYPE2);
  wire        t4_ok   = ucd_q[`UBMS_UCD_T4_SHORT] & ucd_q[`UBMS_UCD_T4_LONG];
  wire        t5_ok   = ucd_q[`UBMS_UCD_T5_SHORT] & ucd_q[`UBMS_UCD_T5_LONG];
  wire        is_leg  = (grant_iuc == `UBMS_IUC_SHORT) | (grant_iuc == `UBMS_IUC_LONG);
  wire        is_adv  = (grant_iuc == `UBMS_IUC_ADV_SHORT) | (grant_iuc == `UBMS_IUC_ADV_LONG);
  wire        conflict = (ch_type == `UBMS_CH_TYPE2) & ((adv_q & is_leg) | (~adv_q & is_adv)); // RQ7
  wire        ctrl_wr = wr & (paddr == `UBMS_CTRL_OFF);
  wire        restart = reg_restart | (ctrl_wr & pwdata[`UBMS_CTRL_REG_RST]);

  // control, capability and descriptor registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `UBMS_CTRL_RST;
      cap_q  <= `UBMS_CAP_RST;
      ucd_q  <= `UBMS_UCD_RST;
    end else if (clk_en) begin
      if (ctrl_wr) begin
        ctrl_q <= pwdata & ~(32'h1 << `UBMS_CTRL_REG_RST); // restart bit self-clears
      end
      if (wr && paddr == `UBMS_CAP_OFF) begin
        cap_q <= pwdata[`UBMS_CAP_W-1:0];
      end
      if (wr && paddr == `UBMS_UCD_OFF) begin
        ucd_q <= pwdata[3:0];
      end
    end
  end

  // mode state: legacy after reset and restart, advanced after the acknowledge on type 2
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_q   <= 1'b0; // RQ19
      acked_q <= 1'b0;
    end else if (clk_en) begin
      if (restart) begin
        adv_q   <= 1'b0; // RQ19
        acked_q <= 1'b0;
      end else if (reg_rsp_rcvd && acked_q) begin
        adv_q   <= 1'b0; // RQ4
        acked_q <= 1'b0;
      end else if (reg_ack_sent) begin
        acked_q <= 1'b1;
        if (ch_type == `UBMS_CH_TYPE2 && adv_cap && t5_ok) begin
          adv_q <= 1'b1; // RQ3
        end
      end else if (ch_type == `UBMS_CH_TYPE3 && adv_cap) begin
        adv_q <= 1'b1; // type 3 carries only advanced data grants
      end else if (ch_type == `UBMS_CH_TYPE1) begin
        adv_q <= 1'b0;
      end
    end
  end

  // grant filter and dropped-grant counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_accept <= 1'b0;
      grant_drop   <= 1'b0;
      drop_cnt_q   <= 16'h0000;
    end else if (clk_en) begin
      grant_accept <= grant_valid & ~conflict;
      grant_drop   <= grant_valid & conflict; // RQ7
      if (wr && paddr == `UBMS_DROP_OFF) begin
        drop_cnt_q <= 16'h0000;
      end else if (grant_valid && conflict && drop_cnt_q != 16'hffff) begin
        drop_cnt_q <= drop_cnt_q + 16'h0001;
      end
    end
  end

  // request sizing, usability and capability gating
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_size_iuc <= `UBMS_IUC_SHORT;
      adv_mode     <= 1'b0;
      chan_usable  <= 1'b0;
      adv_version  <= `UBMS_VER_10;
      use_concat   <= 1'b0;
      use_frag     <= 1'b0;
      use_bpi_plus <= 1'b0;
    end else if (clk_en) begin
      adv_mode <= adv_q;
      if (adv_q) begin
        req_size_iuc <= req_use_long ? `UBMS_IUC_ADV_LONG : `UBMS_IUC_ADV_SHORT; // RQ5
      end else begin
        req_size_iuc <= req_use_long ? `UBMS_IUC_LONG : `UBMS_IUC_SHORT; // RQ1
      end
      // advanced modems may also live on type 5 descriptors alone
      if (adv_cap) begin
        chan_usable <= t4_ok | t5_ok; // RQ11
      end else begin
        chan_usable <= t4_ok & mixed; // RQ10
      end
      // never claim beyond full compliance; hybrids advertise the oldest version
      if (hybrid) begin
        adv_version <= `UBMS_VER_10; // RQ13
      end else if (ver_fully == `UBMS_VER_20 && !adv_cap) begin
        adv_version <= `UBMS_VER_11; // RQ13
      end else begin
        adv_version <= ver_fully; // RQ13
      end
      use_concat   <= cap_q[`UBMS_CAP_CONCAT]; // RQ17
      use_frag     <= cap_q[`UBMS_CAP_FRAG]; // RQ17
      use_bpi_plus <= cap_q[`UBMS_CAP_BPIP]; // RQ17
    end
  end

  // option 60 string: fixed prefix then capability bits as eight ascii hex digits
  function [7:0] hex_chr;
    input [3:0] n;
    begin
      hex_chr = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
    end
  endfunction

  function [7:0] pfx_chr;
    input [3:0] i;
    begin
      case (i)
        4'h0:    pfx_chr = 8'h64;
        4'h1:    pfx_chr = 8'h6f;
        4'h2:    pfx_chr = 8'h63;
        4'h3:    pfx_chr = 8'h73;
        4'h4:    pfx_chr = 8'h69;
        4'h5:    pfx_chr = 8'h73;
        4'h6:    pfx_chr = 8'h31;
        4'h7:    pfx_chr = 8'h2e;
        4'h8:    pfx_chr = 8'h30;
        default: pfx_chr = 8'h3a;
      endcase
    end
  endfunction

  wire [31:0] cap_word = {29'h0, cap_q};
  wire [2:0]  nib_idx  = 3'h7 - opt_cnt_q[2:0] + 3'h2; // digit index, most significant first
  wire [4:0]  dig_pos  = opt_cnt_q - {1'b0, `UBMS_PFX_LEN};
  wire [3:0]  nib      = cap_word[{3'h7 - dig_pos[2:0], 2'h0} +: 4];
  assign opt60_busy = opt_run_q;

  // option 60 sequencer, one character per enabled cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_run_q   <= 1'b0;
      opt_cnt_q   <= 5'h00;
      opt60_valid <= 1'b0;
      opt60_char  <= 8'h00;
    end else if (clk_en) begin
      opt60_valid <= 1'b0;
      if (!opt_run_q) begin
        if (opt60_start && hybrid) begin
          opt_run_q <= 1'b1;
          opt_cnt_q <= 5'h00;
        end
      end else begin
        opt60_valid <= 1'b1;
        if (opt_cnt_q < {1'b0, `UBMS_PFX_LEN}) begin
          opt60_char <= pfx_chr(opt_cnt_q[3:0]); // RQ14
        end else begin
          opt60_char <= hex_chr(nib); // RQ14
        end
        if (opt_cnt_q == `UBMS_MSG_LEN - 5'h01) begin
          opt_run_q <= 1'b0;
        end
        opt_cnt_q <= opt_cnt_q + 5'h01;
      end
    end
  end

  // read mux
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `UBMS_CTRL_OFF: prdata = ctrl_q;
      `UBMS_CAP_OFF:  prdata = {29'h0, cap_q};
      `UBMS_STAT_OFF: prdata = {28'h0, ~adv_q, chan_usable, acked_q, adv_q};
      `UBMS_UCD_OFF:  prdata = {28'h0, ucd_q};
      `UBMS_DROP_OFF: prdata = {16'h0, drop_cnt_q};
      default:        prdata = 32'h0000_0000;
    endcase
  end

  wire unused_ok = &{1'b0, nib_idx};

endmodule
`default_nettype wire
